// *** hw/rst_seq_pkg.sv ***
// Constants, field layout and state codes of the reset and interrupt sequencer.
// Assumes one 20 MHz oscillator reference clock drives the whole block.

`default_nettype none

package rst_seq_pkg;

	//==========================================================
	// Register map
	localparam logic [15:0] ADDR_RESET_CAUSE = 16'hfe01;
	localparam logic [15:0] ADDR_CONFIG_ONE  = 16'h001f;
	localparam logic [15:0] ADDR_WATCHDOG    = 16'hffff;

	// Reset cause field positions
	localparam int RC_POR  = 7;
	localparam int RC_PIN  = 6;
	localparam int RC_WDOG = 5;
	localparam int RC_OPC  = 4;
	localparam int RC_ADR  = 3;
	localparam int RC_MON  = 2;
	localparam int RC_LVI  = 1;
	localparam logic [7:0] RC_RESET = 8'h82;
	localparam logic [7:0] RC_ALL   = 8'hfe;

	// Configuration one: stop instruction enable
	localparam int CFG_STOP_EN = 0;

	//==========================================================
	// Timing in reference clock cycles
	localparam int CNT_W = 13;
	localparam logic [CNT_W-1:0] STAB_CYCLES = 13'h1000;
	localparam logic [CNT_W-1:0] PIN_CYCLES  = 13'h0020;
	localparam logic [CNT_W-1:0] HOLD_CYCLES = 13'h0020;
	localparam logic [1:0] BUS_DIV_LAST = 2'h3;
	localparam int WDOG_W = 24;
	localparam int EXT_W  = 8;

	//==========================================================
	// Vectors
	localparam logic [15:0] VEC_RESET     = 16'hfffe;
	localparam logic [15:0] VEC_RESET_MON = 16'hfefe;
	localparam logic [15:0] VEC_SWI       = 16'hfffc;
	localparam logic [15:0] VEC_IRQ_FIRST = 16'hfffa;
	localparam int IRQ_COUNT = 16;
	localparam int IRQ_IDX_W = 4;

	//==========================================================
	// States
	typedef enum logic [5:0] {
		RS_STAB = 6'h01,
		RS_LOWV = 6'h02,
		RS_PIN  = 6'h04,
		RS_HOLD = 6'h08,
		RS_EXT  = 6'h10,
		RS_RUN  = 6'h20
	} rst_state_t;

	typedef enum logic [1:0] {
		IQ_IDLE  = 2'h1,
		IQ_ENTRY = 2'h2
	} irq_state_t;

endpackage

`default_nettype wire

// *** hw/irq_priority_encoder.sv ***
// Fixed-priority encoder for the peripheral interrupt requests.
// Assumes request bit 0 is the most urgent source.

`timescale 1ns/10ps
`default_nettype none

module irq_priority_encoder (
	input  wire logic [rst_seq_pkg::IRQ_COUNT-1:0] req,
	output logic                                   any,
	output logic [rst_seq_pkg::IRQ_IDX_W-1:0]      index
);

	// Chain of "nothing more urgent pending"
	logic [rst_seq_pkg::IRQ_COUNT:0] clearAbove;
	logic [rst_seq_pkg::IRQ_COUNT-1:0] winner;
	logic [rst_seq_pkg::IRQ_IDX_W-1:0] partial [rst_seq_pkg::IRQ_COUNT:0];

	assign clearAbove[0] = 1'b1;
	assign partial[0] = '0;

	genvar i;
	generate
		for (i = 0; i < rst_seq_pkg::IRQ_COUNT; i++) begin : g_pri
			assign winner[i] = req[i] & clearAbove[i];
			assign clearAbove[i+1] = clearAbove[i] & ~req[i];
			assign partial[i+1] = partial[i] |
				(winner[i] ? rst_seq_pkg::IRQ_IDX_W'(i) : '0);
		end
	endgenerate

	assign any = |req;
	assign index = partial[rst_seq_pkg::IRQ_COUNT];

endmodule

`default_nettype wire

// *** hw/reset_and_interrupt_sequencer.sv ***
// Reset sequencing, reset cause status and interrupt entry control.
// Assumes all inputs are synchronous to clk; the reset pin is open drain
// and resolved outside; the CPU core pulses its strobes for one cycle.

`timescale 1ns/10ps
`default_nettype none

module reset_and_interrupt_sequencer #(
	parameter int WDOG_CYCLES    = 8192,
	parameter int EXT_MIN_CYCLES = 4
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	// Reset pin and supply
	input  wire logic        rstPinIn,
	output logic             rstPinOut,
	output logic             rstPinOe,
	input  wire logic        lowVoltage,
	// CPU events
	input  wire logic        monitorMode,
	input  wire logic        monitorEntryReq,
	input  wire logic        illegalOpcode,
	input  wire logic        stopExecuted,
	input  wire logic        opcodeFetch,
	input  wire logic        fetchUnmapped,
	// Reset outputs
	output logic             cpuReset,
	output logic             clocksGated,
	output logic             busClkTick,
	output logic [15:0]      resetVector,
	// Register port
	input  wire logic [15:0] regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic [7:0]       regRdData,
	// Interrupt entry
	input  wire logic [15:0] irqReq,
	input  wire logic        instrDone,
	input  wire logic        globalMask,
	input  wire logic        swiExecuted,
	input  wire logic        entryDone,
	output logic             intStart,
	output logic             intBusy,
	output logic [15:0]      intVector,
	output logic             pushPcMinusOne,
	output logic             setGlobalMask,
	output logic             stackIndexHigh
);

	//==========================================================
	// Declarations
	rst_seq_pkg::rst_state_t state;
	rst_seq_pkg::rst_state_t next_state;
	rst_seq_pkg::irq_state_t iqState;
	rst_seq_pkg::irq_state_t next_iqState;

	logic [rst_seq_pkg::CNT_W-1:0]  cnt;
	logic [rst_seq_pkg::CNT_W-1:0]  next_cnt;
	logic [rst_seq_pkg::CNT_W-1:0]  cntLimit;
	logic [rst_seq_pkg::WDOG_W-1:0] wdogCnt;
	logic [rst_seq_pkg::EXT_W-1:0]  extCnt;
	logic [7:0]                     flags;
	logic [7:0]                     flagSet;
	logic [7:0]                     flagClr;
	logic [1:0]                     busDiv;
	logic                           stopEnable;

	logic running;
	logic cntDone;
	logic selCause;
	logic selConfig;
	logic selWdog;
	logic rdCause;
	logic wdogOverflow;
	logic badOpcode;
	logic badFetch;
	logic internalEvt;
	logic extEvt;
	logic pinLateLow;
	logic enterLowv;
	logic irqAny;
	logic [rst_seq_pkg::IRQ_IDX_W-1:0] irqIdx;
	logic takeSwi;
	logic takeIrq;
	logic [15:0] irqVec;

	//==========================================================
	// Register decode
	assign selCause  = regAddr == rst_seq_pkg::ADDR_RESET_CAUSE;
	assign selConfig = regAddr == rst_seq_pkg::ADDR_CONFIG_ONE;
	assign selWdog   = regAddr == rst_seq_pkg::ADDR_WATCHDOG;
	assign rdCause   = regRd & selCause;

	//==========================================================
	// Reset sources, only seen while the CPU runs
	assign running = state == rst_seq_pkg::RS_RUN;
	assign wdogOverflow = running &&
		wdogCnt == rst_seq_pkg::WDOG_W'(WDOG_CYCLES - 1);
	assign badOpcode = running &
		(illegalOpcode | (stopExecuted & ~stopEnable));
	// Unmapped data reads are not an input here, so they never reset
	assign badFetch = running & opcodeFetch & fetchUnmapped;
	assign internalEvt = wdogOverflow | badOpcode | badFetch |
		(running & monitorEntryReq);
	assign extEvt = running && !rstPinIn &&
		extCnt == rst_seq_pkg::EXT_W'(EXT_MIN_CYCLES - 1);

	//==========================================================
	// Sequencer counter
	always_comb begin
		unique case (state)
			rst_seq_pkg::RS_STAB: cntLimit = rst_seq_pkg::STAB_CYCLES;
			rst_seq_pkg::RS_PIN:  cntLimit = rst_seq_pkg::PIN_CYCLES;
			rst_seq_pkg::RS_HOLD: cntLimit = rst_seq_pkg::HOLD_CYCLES;
			default:              cntLimit = rst_seq_pkg::PIN_CYCLES;
		endcase
	end

	assign cntDone = cnt == cntLimit - rst_seq_pkg::CNT_W'(1);

	// Pin read back at the end of the hold, 32 cycles after release
	assign pinLateLow = state == rst_seq_pkg::RS_HOLD && cntDone &&
		!rstPinIn;

	//==========================================================
	// Sequencer next state
	always_comb begin
		next_state = state;
		unique case (state)
			rst_seq_pkg::RS_STAB: begin
				if (cntDone) begin
					next_state = rst_seq_pkg::RS_PIN;
				end
			end
			rst_seq_pkg::RS_LOWV: begin
				if (!lowVoltage) begin
					next_state = rst_seq_pkg::RS_STAB;
				end
			end
			rst_seq_pkg::RS_PIN: begin
				if (cntDone) begin
					next_state = rst_seq_pkg::RS_HOLD;
				end
			end
			rst_seq_pkg::RS_HOLD: begin
				if (cntDone) begin
					next_state = rst_seq_pkg::RS_RUN;
				end
			end
			rst_seq_pkg::RS_EXT: begin
				// The chip stays in reset while the outside holds the pin
				if (rstPinIn) begin
					next_state = rst_seq_pkg::RS_HOLD;
				end
			end
			rst_seq_pkg::RS_RUN: begin
				if (internalEvt) begin
					next_state = rst_seq_pkg::RS_PIN;
				end else if (extEvt) begin
					next_state = rst_seq_pkg::RS_EXT;
				end
			end
		endcase
		// A supply drop overrides every other step
		if (lowVoltage) begin
			next_state = rst_seq_pkg::RS_LOWV;
		end
	end

	assign next_cnt = (next_state != state) ? '0 :
		cnt + rst_seq_pkg::CNT_W'(1);
	assign enterLowv = lowVoltage & (state != rst_seq_pkg::RS_LOWV);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= rst_seq_pkg::RS_STAB;
			cnt   <= '0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	//==========================================================
	// Reset outputs, registered from the next state so a reset
	// source stops the core on the following edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cpuReset    <= 1'b1;
			clocksGated <= 1'b1;
			rstPinOe    <= 1'b1;
		end else begin
			cpuReset    <= next_state != rst_seq_pkg::RS_RUN;
			clocksGated <= next_state == rst_seq_pkg::RS_STAB ||
				next_state == rst_seq_pkg::RS_LOWV;
			rstPinOe    <= next_state == rst_seq_pkg::RS_STAB ||
				next_state == rst_seq_pkg::RS_LOWV ||
				next_state == rst_seq_pkg::RS_PIN;
		end
	end

	// Open drain: only ever pulls low
	assign rstPinOut = 1'b0;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			resetVector <= rst_seq_pkg::VEC_RESET;
		end else begin
			resetVector <= monitorMode ? rst_seq_pkg::VEC_RESET_MON :
				rst_seq_pkg::VEC_RESET;
		end
	end

	//==========================================================
	// Bus clock tick: reference divided by four, phase restarted
	// by every reset so the first bus cycle is aligned
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busDiv     <= '0;
			busClkTick <= 1'b0;
		end else if (cpuReset) begin
			busDiv     <= '0;
			busClkTick <= 1'b0;
		end else begin
			busDiv     <= busDiv + 2'h1;
			busClkTick <= busDiv == rst_seq_pkg::BUS_DIV_LAST;
		end
	end

	//==========================================================
	// Watchdog counter and external pin low-time filter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wdogCnt <= '0;
		end else if (!running || wdogOverflow ||
			(regWr && selWdog)) begin
			wdogCnt <= '0;
		end else begin
			wdogCnt <= wdogCnt + rst_seq_pkg::WDOG_W'(1);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			extCnt <= '0;
		end else if (!running || rstPinIn) begin
			extCnt <= '0;
		end else if (!extEvt) begin
			extCnt <= extCnt + rst_seq_pkg::EXT_W'(1);
		end
	end

	//==========================================================
	// Reset cause flags
	always_comb begin
		flagSet = '0;
		flagSet[rst_seq_pkg::RC_PIN]  = extEvt | pinLateLow;
		flagSet[rst_seq_pkg::RC_WDOG] = wdogOverflow;
		flagSet[rst_seq_pkg::RC_OPC]  = badOpcode;
		flagSet[rst_seq_pkg::RC_ADR]  = badFetch;
		flagSet[rst_seq_pkg::RC_MON]  = running & monitorEntryReq;
		flagSet[rst_seq_pkg::RC_LVI]  = enterLowv;
	end

	assign flagClr = rdCause ? 8'hff : 8'h00;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flags <= rst_seq_pkg::RC_RESET;
		end else begin
			flags <= (flags & ~flagClr) | flagSet;
		end
	end

	//==========================================================
	// Configuration one; the stop enable returns to 0 on any reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stopEnable <= 1'b0;
		end else if (cpuReset) begin
			stopEnable <= 1'b0;
		end else if (regWr && selConfig) begin
			stopEnable <= regWrData[rst_seq_pkg::CFG_STOP_EN];
		end
	end

	//==========================================================
	// Register read data, valid the cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			regRdData <= '0;
		end else if (regRd && selCause) begin
			regRdData <= flags & rst_seq_pkg::RC_ALL;
		end else if (regRd && selConfig) begin
			regRdData <= {7'h00, stopEnable};
		end else begin
			regRdData <= '0;
		end
	end

	//==========================================================
	// Interrupt arbitration
	irq_priority_encoder u_pri (
		.req   (irqReq),
		.any   (irqAny),
		.index (irqIdx)
	);

	assign irqVec = rst_seq_pkg::VEC_IRQ_FIRST -
		{11'h000, irqIdx, 1'b0};
	// Decisions only at an instruction boundary, so nothing aborts
	assign takeSwi = instrDone & swiExecuted;
	assign takeIrq = instrDone & ~swiExecuted & ~globalMask &
		irqAny;

	always_comb begin
		next_iqState = iqState;
		unique case (iqState)
			rst_seq_pkg::IQ_IDLE: begin
				if (takeSwi || takeIrq) begin
					next_iqState = rst_seq_pkg::IQ_ENTRY;
				end
			end
			rst_seq_pkg::IQ_ENTRY: begin
				// Latched source holds until stacking completes
				if (entryDone) begin
					next_iqState = rst_seq_pkg::IQ_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			iqState <= rst_seq_pkg::IQ_IDLE;
		end else if (cpuReset) begin
			iqState <= rst_seq_pkg::IQ_IDLE;
		end else begin
			iqState <= next_iqState;
		end
	end

	assign intBusy = iqState == rst_seq_pkg::IQ_ENTRY;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			intStart       <= 1'b0;
			setGlobalMask  <= 1'b0;
			intVector      <= rst_seq_pkg::VEC_SWI;
			pushPcMinusOne <= 1'b0;
		end else begin
			intStart      <= 1'b0;
			setGlobalMask <= 1'b0;
			if (!cpuReset && iqState == rst_seq_pkg::IQ_IDLE &&
				(takeSwi || takeIrq)) begin
				intStart       <= 1'b1;
				setGlobalMask  <= 1'b1;
				intVector      <= takeSwi ? rst_seq_pkg::VEC_SWI :
					irqVec;
				pushPcMinusOne <= ~takeSwi;
			end
		end
	end

	// Index high is never part of the stack frame
	assign stackIndexHigh = 1'b0;

endmodule

`default_nettype wire

// *** bench/rst_seq_properties.sv ***
// Port checker for the reset and interrupt sequencer.
// Assumes a bind onto the top module and one clock domain.
`timescale 1ns/10ps
`default_nettype none
module rst_seq_properties (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        rstPinOut,
	input wire logic        rstPinOe,
	input wire logic        illegalOpcode,
	input wire logic        cpuReset,
	input wire logic        clocksGated,
	input wire logic        busClkTick,
	input wire logic        monitorMode,
	input wire logic [15:0] resetVector,
	input wire logic [15:0] irqReq,
	input wire logic        instrDone,
	input wire logic        globalMask,
	input wire logic        swiExecuted,
	input wire logic        entryDone,
	input wire logic        intStart,
	input wire logic        intBusy,
	input wire logic [15:0] intVector,
	input wire logic        pushPcMinusOne,
	input wire logic        setGlobalMask,
	input wire logic        stackIndexHigh
);
	//====
	// Age since release, trusted for the power-on sequence only
	logic [12:0] age;
	logic        first;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			age <= 13'h0000;
			first <= 1'b1;
		end else begin
			age <= age + {12'h000, age != 13'h1fff};
			first <= first && cpuReset;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	//====
	sequence s_pin;
		rstPinOe && cpuReset ##31 rstPinOe ##1 !rstPinOe && cpuReset;
	endsequence
	sequence s_hold;
		cpuReset ##30 cpuReset ##1 !cpuReset;
	endsequence
	property p_internal;
		illegalOpcode && !cpuReset |=> s_pin ##1 s_hold;
	endproperty
	a_internal: assert property (p_internal)
		else $error("internal reset timing wrong");
	property p_por_pin;
		first && $fell(rstPinOe) |-> age >= 13'h101e && age <= 13'h1024;
	endproperty
	a_por_pin: assert property (p_por_pin)
		else $error("power-on pin release time wrong");
	property p_por_cpu;
		first && $fell(cpuReset) |-> age >= 13'h103e && age <= 13'h1044;
	endproperty
	a_por_cpu: assert property (p_por_cpu)
		else $error("power-on cpu release time wrong");
	property p_por_gate;
		first && age < 13'h0ff0 |-> rstPinOe && clocksGated && cpuReset;
	endproperty
	a_por_gate: assert property (p_por_gate)
		else $error("clocks or pin free during stabilisation");
	property p_no_int;
		!instrDone |=> !intStart;
	endproperty
	a_no_int: assert property (p_no_int)
		else $error("entry before instruction done");
	property p_masked;
		instrDone && !swiExecuted && (globalMask || irqReq == 16'h0000)
			|=> !intStart;
	endproperty
	a_masked: assert property (p_masked)
		else $error("masked or absent request entered");
	property p_swi;
		instrDone && swiExecuted && !intBusy && !cpuReset |=> intStart &&
			setGlobalMask && intVector == 16'hfffc && !pushPcMinusOne;
	endproperty
	a_swi: assert property (p_swi)
		else $error("software interrupt entry wrong");
	property p_busy;
		intBusy && !entryDone |=> intBusy && !intStart;
	endproperty
	a_busy: assert property (p_busy)
		else $error("entry preempted");
	property p_stack;
		rstPinOut == 1'b0 && stackIndexHigh == 1'b0;
	endproperty
	a_stack: assert property (p_stack)
		else $error("index high stacked or pin data high");
	property p_tick;
		busClkTick && !cpuReset |=>
			!busClkTick [*3] ##1 (busClkTick || cpuReset);
	endproperty
	a_tick: assert property (p_tick)
		else $error("bus clock not divide by four");
	property p_vec;
		1'b1 |=> resetVector == ($past(monitorMode) ? 16'hfefe : 16'hfffe);
	endproperty
	a_vec: assert property (p_vec)
		else $error("reset vector wrong");
endmodule
`default_nettype wire

// *** bench/cpu_core_model.sv ***
// Far side: reset pin with pull-up, outside reset driver, core stacking.
// Assumes the bench commands extLow and slow.
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
	input  wire logic clk,
	input  wire logic rstPinOe,
	input  wire logic extLow,
	input  wire logic slow,
	input  wire logic intStart,
	output logic      rstPinIn,
	output logic      entryDone
);
	logic [3:0] left = 4'h0;
	// Open drain: pulled up unless either party pulls it low
	assign rstPinIn = !(rstPinOe || extLow);
	// Stacking and vector load take two or nine cycles
	always @(posedge clk) begin
		entryDone <= (left == 4'h1);
		if (intStart)
			left <= slow ? 4'h9 : 4'h2;
		else if (left != 4'h0)
			left <= left - 4'h1;
	end
endmodule
`default_nettype wire

// *** bench/reset_and_interrupt_sequencer_tb_top.sv ***
// Self-checking bench for the reset and interrupt sequencer.
// Assumes the core model and the port checker beside it.
`timescale 1ns/10ps
`default_nettype none
module reset_and_interrupt_sequencer_tb_top;
	logic        clk, resetn, rstPinIn, rstPinOut, rstPinOe, lowVoltage;
	logic        monitorMode, fetchUnmapped, cpuReset, clocksGated;
	logic        busClkTick, regWr, regRd, instrDone, globalMask;
	logic        swiExecuted, entryDone, intStart, intBusy, pushPcMinusOne;
	logic        setGlobalMask, stackIndexHigh, extLow, slow;
	logic        rdPend = 1'b0;
	logic [3:0]  evt;
	logic [7:0]  regWrData, regRdData, flags;
	logic [15:0] resetVector, regAddr, irqReq, intVector;
	logic [16:0] expInt[$];
	logic [7:0]  expRd[$];
	logic [31:0] seed = 32'hf2e2;
	int          failures = 0, comparisons = 0, i;

	reset_and_interrupt_sequencer #(.WDOG_CYCLES(256), .EXT_MIN_CYCLES(4))
	u_reset_and_interrupt_sequencer (
		.clk, .resetn, .rstPinIn, .rstPinOut, .rstPinOe, .lowVoltage,
		.monitorMode, .monitorEntryReq(evt[3]), .illegalOpcode(evt[0]),
		.stopExecuted(evt[1]), .opcodeFetch(evt[2]), .fetchUnmapped,
		.cpuReset, .clocksGated, .busClkTick, .resetVector, .regAddr,
		.regWrData, .regWr, .regRd, .regRdData, .irqReq, .instrDone,
		.globalMask, .swiExecuted, .entryDone, .intStart, .intBusy,
		.intVector, .pushPcMinusOne, .setGlobalMask, .stackIndexHigh
	);
	cpu_core_model u_cpu_core_model (
		.clk, .rstPinOe, .extLow, .slow, .intStart, .rstPinIn, .entryDone
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	//====
	// Helpers
	function automatic logic [31:0] nxt(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input string what, input logic [16:0] e,
		input logic [16:0] s);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic complete_run();
		chk("intQueue", 17'h00000, 17'(expInt.size()));
		chk("rdQueue", 17'h00000, 17'(expRd.size()));
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	// A read may carry an event strobe in the same cycle
	task automatic rd(input logic [15:0] a, input logic [7:0] e,
		input logic [3:0] v);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		evt <= v;
		expRd.push_back(e);
		@(posedge clk);
		regRd <= 1'b0;
		evt <= 4'h0;
	endtask
	task automatic cause();
		rd(16'hfe01, flags, 4'h0);
		flags = 8'h00;
	endtask
	// Waits out any reset, then kicks the watchdog
	task automatic settle();
		int k;
		@(posedge clk);
		for (k = 0; k < 9000 && cpuReset !== 1'b0; k++)
			@(negedge clk);
		wr(16'hffff, 8'h00);
	endtask
	task automatic ext(input int n, input logic [7:0] f, input logic lv);
		@(posedge clk);
		{lowVoltage, extLow} <= lv ? 2'h2 : 2'h1;
		repeat (n) @(posedge clk);
		{lowVoltage, extLow} <= 2'h0;
		flags = flags | f;
		settle();
	endtask
	// A nonzero hold keeps the pin low past the device's own release
	task automatic ev(input logic [3:0] e, input logic [7:0] f, input int h);
		@(posedge clk);
		evt <= e;
		@(posedge clk);
		evt <= 4'h0;
		flags = flags | f;
		if (h != 0)
			ext(h, 8'h40, 1'b0);
		else
			settle();
	endtask
	// A second completion lands while busy and must not start an entry
	task automatic irq(input logic [15:0] r, input logic s, input logic m);
		int k;
		logic [16:0] e;
		e = s ? 17'h0fffc : 17'h00000;
		if (!s && !m)
			for (k = 15; k >= 0; k--)
				if (r[k])
					e = {1'b1, 16'hfffa - 16'(2 * k)};
		if (e != 17'h00000)
			expInt.push_back(e);
		@(posedge clk);
		{irqReq, swiExecuted, globalMask, instrDone} <= {r, s, m, 1'b1};
		@(posedge clk);
		instrDone <= 1'b0;
		@(posedge clk);
		instrDone <= 1'b1;
		@(posedge clk);
		instrDone <= 1'b0;
		for (k = 0; k < 20 && intBusy !== 1'b0; k++)
			@(negedge clk);
		wr(16'hffff, 8'h00);
	endtask

	//====
	// Result watcher
	always @(posedge clk) begin
		rdPend <= regRd;
		if (rdPend)
			chk("regRdData", {9'h000, expRd.pop_front()},
				{9'h000, regRdData});
		if (intStart === 1'b1) begin
			chk("intEntry", expInt.size() ? expInt.pop_front() : 17'h00000,
				{pushPcMinusOne, intVector});
			chk("setGlobalMask", 17'h00001, {16'h0000, setGlobalMask});
		end
	end

	initial begin
		#2000000;
		failures++;
		complete_run();
	end

	//====
	// Scenarios
	initial begin
		{resetn, lowVoltage, monitorMode, fetchUnmapped, regWr, regRd} = 6'h00;
		{instrDone, globalMask, swiExecuted, extLow, slow} = 5'h00;
		{evt, regWrData, regAddr, irqReq, flags} = 52'h0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		settle();
		flags = 8'h82;
		cause();
		cause();
		rd(16'h0100, 8'h00, 4'h0);
		ev(4'h1, 8'h10, 0);
		ev(4'h2, 8'h10, 0);
		cause();
		wr(16'h001f, 8'h01);
		ev(4'h2, 8'h00, 0);
		ev(4'h4, 8'h00, 0);
		// Neither event above may leave a flag behind
		cause();
		fetchUnmapped <= 1'b1;
		repeat (20) @(posedge clk);
		ev(4'h4, 8'h08, 0);
		monitorMode <= 1'b1;
		ev(4'h8, 8'h04, 0);
		@(negedge clk);
		chk("resetVector", 17'h0fefe, {1'b0, resetVector});
		@(posedge clk);
		monitorMode <= 1'b0;
		cause();
		rd(16'hfe01, flags, 4'h1);
		flags = 8'h10;
		settle();
		cause();
		ext(3, 8'h00, 1'b0);
		ext(6, 8'h40, 1'b0);
		ev(4'h4, 8'h08, 80);
		cause();
		for (i = 0; i < 3; i++) begin
			repeat (200) @(posedge clk);
			seed = nxt(seed);
			wr(16'hffff, seed[7:0]);
		end
		@(negedge clk);
		chk("cpuReset", 17'h00000, {16'h0000, cpuReset});
		repeat (300) @(posedge clk);
		flags = flags | 8'h20;
		settle();
		cause();
		ext(10, 8'h02, 1'b1);
		cause();
		irq(16'h0004, 1'b0, 1'b0);
		irq(16'h8000, 1'b0, 1'b0);
		irq(16'hffff, 1'b0, 1'b1);
		irq(16'h0000, 1'b1, 1'b1);
		for (i = 0; i < 12; i++) begin
			seed = nxt(seed);
			slow <= seed[23];
			irq(seed[15:0] << seed[19:16], seed[20] & seed[21], seed[22]);
		end
		complete_run();
	end
endmodule

bind reset_and_interrupt_sequencer rst_seq_properties u_rst_seq_properties (
	.clk, .resetn, .rstPinOut, .rstPinOe, .illegalOpcode, .cpuReset,
	.clocksGated, .busClkTick, .monitorMode, .resetVector, .irqReq,
	.instrDone, .globalMask, .swiExecuted, .entryDone, .intStart,
	.intBusy, .intVector, .pushPcMinusOne, .setGlobalMask, .stackIndexHigh
);
`default_nettype wire
